// ==== rtl/osw_clockout.sv ====
/*
 * Oscillator supervisor, internal phase timing, clock output and chip
 * reset merge, with an APB register slave.
 * Assumes crystal, enable and reset pins arrive asynchronous to clk_sys
 * and that the oscillator stays below half the clk_sys rate.
 */
`timescale 1ns/100ps
`default_nettype none
`include "osw_map.svh"

module osw_clockout #(
    parameter int REF_CYCLES = `OSW_REF_CYCLES,
    parameter int RECOVER_EDGES = `OSW_RECOVER_EDGES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic crystalIn,
    input wire logic oscSuperviseEnablePin,
    input wire logic extResetN,
    input wire logic wdtReset,
    input wire logic slowDownMode,
    input wire logic externalMoveInstr,
    input wire logic [7:0] portOutLatch,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic chipReset,
    output logic state3Phase1,
    output logic state3Phase2,
    output logic portOneSixOut,
    output logic [7:0] portPins
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] xtalSync_q;
    logic [1:0] enSync_q;
    logic [1:0] extSync_q;
    logic xtalLast_q;
    logic oscEdge;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            xtalSync_q <= 2'b00;
            enSync_q <= 2'b11;
            extSync_q <= 2'b11;
            xtalLast_q <= 1'b0;
        end else begin
            xtalSync_q <= {xtalSync_q[0], crystalIn};
            enSync_q <= {enSync_q[0], oscSuperviseEnablePin};
            extSync_q <= {extSync_q[0], extResetN};
            xtalLast_q <= xtalSync_q[1];
        end
    end

    // raw oscillator edge, never the divided cpu clock
    assign oscEdge = xtalSync_q[1] & ~xtalLast_q;

    logic superviseOn;
    logic extResetHit;
    assign superviseOn = enSync_q[1];
    assign extResetHit = ~extSync_q[1];

    // ------------------------------------------------------------
    // reference period and frequency comparator
    // ------------------------------------------------------------
    logic [15:0] refCnt_q;
    logic refTick;
    logic edgeSeen_q;
    logic failNow;

    assign refTick = (refCnt_q == 16'(REF_CYCLES - 1));

    always_ff @(posedge clk_sys) begin
        if (rst || refTick) begin
            refCnt_q <= 16'h0000;
        end else begin
            refCnt_q <= refCnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || refTick) begin
            edgeSeen_q <= 1'b0;
        end else if (oscEdge) begin
            edgeSeen_q <= 1'b1;
        end
    end

    // no oscillator edge in a whole reference period: slower than reference
    assign failNow = refTick & ~edgeSeen_q & ~oscEdge & superviseOn;

    // ------------------------------------------------------------
    // supervisor state
    // ------------------------------------------------------------
    osw_pkg::osw_state_type state_q;
    osw_pkg::osw_state_type state_d;
    logic [1:0] recoverCnt_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            osw_pkg::OSW_GOOD: begin
                if (failNow) begin
                    state_d = osw_pkg::OSW_FAILED;
                end
            end
            osw_pkg::OSW_FAILED: begin
                if (oscEdge) begin
                    state_d = osw_pkg::OSW_RECOVER;
                end
            end
            osw_pkg::OSW_RECOVER: begin
                if (failNow) begin
                    state_d = osw_pkg::OSW_FAILED;
                end else if (oscEdge && recoverCnt_q == 2'(RECOVER_EDGES - 1)) begin
                    state_d = osw_pkg::OSW_GOOD;
                end
            end
            default: begin
                state_d = osw_pkg::OSW_GOOD;
            end
        endcase
        if (!superviseOn) begin
            state_d = osw_pkg::OSW_GOOD;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= osw_pkg::OSW_GOOD;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || state_q != osw_pkg::OSW_RECOVER) begin
            recoverCnt_q <= 2'b00;
        end else if (oscEdge) begin
            recoverCnt_q <= recoverCnt_q + 2'b01;
        end
    end

    logic failReset;
    assign failReset = (state_q != osw_pkg::OSW_GOOD);

    // ------------------------------------------------------------
    // chip reset merge
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chipReset <= 1'b1;
        end else begin
            chipReset <= failReset | extResetHit | wdtReset;
        end
    end

    // ------------------------------------------------------------
    // phase timing: one step per oscillator edge, two phases per state
    // ------------------------------------------------------------
    logic [3:0] phaseCnt_q;
    logic [2:0] slowCnt_q;
    logic cycleEnd;

    assign cycleEnd = oscEdge && phaseCnt_q == 4'(`OSW_PHASES_PER_CYCLE - 1);

    always_ff @(posedge clk_sys) begin
        if (rst || chipReset) begin
            phaseCnt_q <= 4'h0;
        end else if (cycleEnd) begin
            phaseCnt_q <= 4'h0;
        end else if (oscEdge) begin
            phaseCnt_q <= phaseCnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || chipReset || !slowDownMode) begin
            slowCnt_q <= 3'h0;
        end else if (cycleEnd) begin
            slowCnt_q <= slowCnt_q + 3'h1;
        end
    end

    logic highPhA;
    logic highPhB;
    logic slowGate;
    assign highPhA = (phaseCnt_q == 4'(`OSW_HIGH_PH_A));
    assign highPhB = (phaseCnt_q == 4'(`OSW_HIGH_PH_B));
    // a strobed external move keeps its state three high even when slowed
    assign slowGate = !slowDownMode || slowCnt_q == 3'h0 || externalMoveInstr;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state3Phase1 <= 1'b0;
            state3Phase2 <= 1'b0;
        end else begin
            state3Phase1 <= highPhA & ~chipReset;
            state3Phase2 <= highPhB & ~chipReset;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] adcCtl_q;
    osw_pkg::osw_ctrl_type ctrl_q;
    logic failFlag_q;
    // reset value split per field: the struct is narrower than the map word
    localparam logic [7:0] CTRL_RST = `OSW_CTRL_RST;
    logic [9:0] regIdx;
    logic wrEn;
    logic mapped;

    assign regIdx = paddr[11:2];
    assign wrEn = psel & penable & pready & pwrite;
    assign mapped = regIdx == `OSW_IDX_ADCCTL || regIdx == `OSW_IDX_STATUS
                 || regIdx == `OSW_IDX_CTRL || regIdx == `OSW_IDX_LIVE;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            adcCtl_q <= `OSW_ADCCTL_RST;
        end else if (wrEn && regIdx == `OSW_IDX_ADCCTL) begin
            adcCtl_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q.slowDown <= CTRL_RST[`OSW_BIT_SLOW];
            ctrl_q.pinLatch <= CTRL_RST[`OSW_BIT_LATCH];
        end else if (wrEn && regIdx == `OSW_IDX_CTRL) begin
            ctrl_q.slowDown <= pwdata[`OSW_BIT_SLOW];
            ctrl_q.pinLatch <= pwdata[`OSW_BIT_LATCH];
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst || extResetHit) begin
            failFlag_q <= 1'b0;
        end else if (failNow) begin
            failFlag_q <= 1'b1;
        end else if (wrEn && regIdx == `OSW_IDX_STATUS) begin
            failFlag_q <= pwdata[`OSW_BIT_FAILFLAG];
        end
    end

    osw_pkg::osw_live_type live;
    assign live = '{superviseOn: superviseOn, failReset: failReset,
                    oscFailed: (state_q == osw_pkg::OSW_FAILED)};

    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        case (regIdx)
            `OSW_IDX_ADCCTL: rdMux[7:0] = adcCtl_q;
            `OSW_IDX_STATUS: rdMux[`OSW_BIT_FAILFLAG] = failFlag_q;
            `OSW_IDX_CTRL: begin
                rdMux[`OSW_BIT_SLOW] = ctrl_q.slowDown;
                rdMux[`OSW_BIT_LATCH] = ctrl_q.pinLatch;
            end
            `OSW_IDX_LIVE: rdMux[2:0] = live;
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // one wait-free access phase: answer prepared during setup
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata <= (psel && !penable && !pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // pins: clock output and forced ones under failure reset
    // ------------------------------------------------------------
    logic clkOutLevel;
    assign clkOutLevel = (highPhA | highPhB) & slowGate;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            portOneSixOut <= 1'b1;
            portPins <= 8'hff;
        end else if (chipReset) begin
            portOneSixOut <= 1'b1;
            portPins <= 8'hff;
        end else begin
            // latch must hold one or the output stays low
            portOneSixOut <= ctrl_q.pinLatch
                & (adcCtl_q[`OSW_BIT_CLKEN] ? clkOutLevel : 1'b1);
            portPins <= portOutLatch;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_fail_enters: assert property (failNow |=> state_q == osw_pkg::OSW_FAILED)
        else $error("failure not entered");
    a_reset_merge: assert property (failReset |=> chipReset)
        else $error("failure reset not merged");
    a_ports_high: assert property (chipReset |=> portPins == 8'hff && portOneSixOut)
        else $error("ports not high under reset");
    a_recover_hold: assert property (
        state_q == osw_pkg::OSW_FAILED ##1 state_q == osw_pkg::OSW_RECOVER
        |-> failReset [*2])
        else $error("recovery reset too short");
    a_disable_off: assert property (!superviseOn |=> !failReset)
        else $error("supervision not disabled");
    a_flag_set: assert property (failNow && !extResetHit |=> failFlag_q)
        else $error("failure flag not set");
    a_slow_no_fail: assert property (edgeSeen_q && refTick |-> !failNow)
        else $error("false failure");
    a_system_clock_output_gate: assert property (
        !chipReset && ctrl_q.pinLatch && adcCtl_q[`OSW_BIT_CLKEN]
        |=> portOneSixOut == $past(clkOutLevel))
        else $error("clock output wrong");
    a_high_state3: assert property (clkOutLevel |-> highPhA || highPhB)
        else $error("clock output outside state three");
    a_slow_div: assert property (slowDownMode && slowCnt_q != 3'h0
        && !externalMoveInstr |-> !clkOutLevel)
        else $error("slow divide missing");

    c_fail_seen: cover property (failNow);
    c_recovered: cover property (state_q == osw_pkg::OSW_RECOVER ##1 state_q == osw_pkg::OSW_GOOD);
    c_system_clock_output_high: cover property (portOneSixOut && adcCtl_q[`OSW_BIT_CLKEN] && !chipReset);
    c_slow_edge: cover property (slowDownMode && cycleEnd);
endmodule : osw_clockout
`default_nettype wire

// ==== rtl/osw_map.svh ====
/*
 * Register map, field positions, reset values and timing counts of the
 * oscillator supervisor and clock output block.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
// Summary of operation
// - A failure reset is requested when the oscillator runs slower than the reference.
// - The failure reset stays on while failed and three oscillator cycles after recovery.
// - While that reset is held every port pin shows a one.
// - The reference runs at 300 kHz and is the failure threshold.
// - The comparator watches the raw oscillator, so slow-down never causes a failure.
// - Supervision is off while the enable pin is low, on while high or open.
// - A failure sets a status flag, cleared by outside hardware reset or by software.
// - Phases run at the oscillator rate, states at half of it, machine cycles at osc/12.
// - With the clock-out enable bit set pin six of port one carries osc/12.
// - The clock output is high only in phases one and two of state three.
// - During an external move the high phase falls in the last strobed state three.
// - In slow-down mode the clock output is divided by a further eight.
// - The failure flag is the top bit of the status register, settable by software.
`ifndef OSW_MAP_SVH
`define OSW_MAP_SVH

// register indices; byte address is four times the index
`define OSW_IDX_ADCCTL 10'h0d8
`define OSW_IDX_STATUS 10'h0a9
`define OSW_IDX_CTRL 10'h000
`define OSW_IDX_LIVE 10'h001

`define OSW_BIT_CLKEN 6
`define OSW_BIT_FAILFLAG 7
`define OSW_BIT_SLOW 0
`define OSW_BIT_LATCH 1

`define OSW_ADCCTL_RST 8'h00
`define OSW_CTRL_RST 8'h02

`define OSW_CLK_KHZ 25000
`define OSW_REF_KHZ 300
`define OSW_REF_CYCLES (`OSW_CLK_KHZ / `OSW_REF_KHZ)
`define OSW_RECOVER_EDGES 3
`define OSW_PHASES_PER_CYCLE 12
`define OSW_HIGH_PH_A 4
`define OSW_HIGH_PH_B 5
`define OSW_SLOW_DIV 8

`endif

// ==== rtl/osw_pkg.sv ====
/*
 * Types shared by the oscillator supervisor block.
 * Assumes osw_map.svh supplies all numbers.
 */
`default_nettype none
package osw_pkg;
    // supervisor states, gray along good -> failed -> recover, two bits change back to good
    typedef enum logic [1:0] {
        OSW_GOOD = 2'b00,
        OSW_FAILED = 2'b01,
        OSW_RECOVER = 2'b11
    } osw_state_type;

    typedef struct packed {
        logic slowDown;
        logic pinLatch;
    } osw_ctrl_type;

    typedef struct packed {
        logic superviseOn;
        logic failReset;
        logic oscFailed;
    } osw_live_type;
endpackage : osw_pkg
`default_nettype wire

// ==== test/osw_xtal_model.sv ====
/*
 * crystal oscillator model feeding the raw oscillator pin.
 * assumes clk_sys runs well above the oscillator rate.
 */
`timescale 1ns/100ps
`default_nettype none
module osw_xtal_model (
    input wire logic clk_sys,
    input wire logic run,
    input wire logic [7:0] halfPer,
    output logic crystalIn
);
    logic [7:0] cnt_q;
    // a dead crystal sits low, it never keeps toggling
    always_ff @(posedge clk_sys) begin
        if (!run) begin
            cnt_q <= 8'h00;
            crystalIn <= 1'b0;
        end else if (cnt_q + 8'h01 >= halfPer) begin
            cnt_q <= 8'h00;
            crystalIn <= ~crystalIn;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule : osw_xtal_model
`default_nettype wire

// ==== test/tb_top.sv ====
/*
 * self-checking bench of the oscillator supervisor and clock output.
 * assumes the wait-free APB slave and the crystal model beside it.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int HALF = 4;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic xRun = 1'b0;
    logic state3Phase1;
    logic state3Phase2;
    logic crystalIn;
    logic oscSuperviseEnablePin = 1'b1;
    logic extResetN = 1'b1;
    logic wdtReset = 1'b0;
    logic slowDownMode = 1'b0;
    logic externalMoveInstr = 1'b0;
    logic [7:0] portOutLatch = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic chipReset;
    logic portOneSixOut;
    logic [7:0] portPins;
    int errors = 0;
    int comparisons = 0;

    osw_xtal_model i_osw_xtal_model (.clk_sys(clk_sys), .run(xRun), .halfPer(8'(HALF)),
        .crystalIn(crystalIn));

    // short reference period keeps failure runs brief
    osw_clockout #(.REF_CYCLES(20), .RECOVER_EDGES(3)) i_osw_clockout (
        .clk_sys(clk_sys), .rst(rst), .crystalIn(crystalIn),
        .oscSuperviseEnablePin(oscSuperviseEnablePin), .extResetN(extResetN),
        .wdtReset(wdtReset), .slowDownMode(slowDownMode),
        .externalMoveInstr(externalMoveInstr), .portOutLatch(portOutLatch),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .chipReset(chipReset),
        .state3Phase1(state3Phase1), .state3Phase2(state3Phase2),
        .portOneSixOut(portOneSixOut),
        .portPins(portPins));

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic int exp_period(input logic slow);
        return 2 * HALF * 12 * (slow ? 8 : 1);
    endfunction : exp_period

    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            errors++;
            $display("CHECK FAILED wait expected done seen timeout");
            print_verdict();
        end
    endtask : tmo

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        tmo(n, 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x,
        input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(nm, r, x);
        chk("pslverr", {31'h0, e}, {31'h0, xe});
    endtask : rd

    task automatic wait_out(input logic v, inout int n);
        while (portOneSixOut !== v && n < 9000) begin
            @(posedge clk_sys);
            n++;
        end
    endtask : wait_out

    task automatic wait_rst(input logic v, output int n);
        n = 0;
        while (chipReset !== v && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        tmo(n, 400);
    endtask : wait_rst

    initial begin
        int per;
        int hi;
        int t0;
        int n;
        logic [31:0] v;
        void'($urandom(32'hd390));
        // the crystal model has no reset: hold it stopped first so it starts clean
        repeat (10) @(posedge clk_sys);
        xRun <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd("adcctl", 12'h360, 32'h0000_0000, 1'b0);
        rd("ctrl", 12'h000, 32'h0000_0002, 1'b0);
        rd("status", 12'h2a4, 32'h0000_0000, 1'b0);
        rd("unmapped", 12'h100, 32'h0000_0000, 1'b1);
        for (int i = 0; i < 4; i++) begin
            v = $urandom & 32'h0000_00bf;
            wr(12'h360, v);
            rd("adcctl", 12'h360, v, 1'b0);
            portOutLatch <= 8'($urandom);
            repeat (3) @(posedge clk_sys);
            chk("pins", {24'h0, portPins}, {24'h0, portOutLatch});
        end
        wr(12'h000, 32'h0000_0000);
        repeat (3) @(posedge clk_sys);
        chk("latch_low", {31'h0, portOneSixOut}, 32'h0000_0000);
        wr(12'h000, 32'h0000_0002);
        repeat (3) @(posedge clk_sys);
        chk("latch_high", {31'h0, portOneSixOut}, 32'h0000_0001);
        wr(12'h360, 32'h0000_0040);
        // plain, slow-down, slow-down during an external move
        for (int m = 0; m < 3; m++) begin
            slowDownMode <= (m > 0);
            externalMoveInstr <= (m == 2);
            n = 0;
            wait_out(1'b0, n);
            wait_out(1'b1, n);
            t0 = n;
            chk("ph1_at_rise", {31'h0, state3Phase1}, 32'h0000_0001);
            chk("ph2_at_rise", {31'h0, state3Phase2}, 32'h0000_0000);
            wait_out(1'b0, n);
            hi = n - t0;
            wait_out(1'b1, n);
            per = n - t0;
            tmo(n, 9000);
            chk("period", per, exp_period(m == 1));
            chk("high", hi, 4 * HALF);
            chk("slow_ok", {31'h0, chipReset}, 32'h0000_0000);
        end
        chk("move_period", per, exp_period(1'b0));
        slowDownMode <= 1'b0;
        externalMoveInstr <= 1'b0;
        wdtReset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("wdt_reset", {31'h0, chipReset}, 32'h0000_0001);
        wdtReset <= 1'b0;
        wait_rst(1'b0, n);
        oscSuperviseEnablePin <= 1'b0;
        xRun <= 1'b0;
        t0 = 0;
        repeat (200) begin
            @(posedge clk_sys);
            if (chipReset !== 1'b0) t0++;
        end
        chk("off_no_reset", t0, 0);
        oscSuperviseEnablePin <= 1'b1;
        wait_rst(1'b1, n);
        chk("fail_reset", {31'h0, chipReset}, 32'h0000_0001);
        // pins follow chipReset one edge later
        @(posedge clk_sys);
        chk("pins_ones", {24'h0, portPins}, 32'h0000_00ff);
        chk("pin16_one", {31'h0, portOneSixOut}, 32'h0000_0001);
        xRun <= 1'b1;
        wait_rst(1'b0, n);
        chk("recover_len", {31'h0, n >= 3 * 2 * HALF}, 32'h0000_0001);
        rd("flag_set", 12'h2a4, 32'h0000_0080, 1'b0);
        wr(12'h2a4, 32'h0000_0000);
        rd("flag_sw_clr", 12'h2a4, 32'h0000_0000, 1'b0);
        wr(12'h2a4, 32'h0000_0080);
        rd("flag_sw_set", 12'h2a4, 32'h0000_0080, 1'b0);
        extResetN <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk("ext_reset", {31'h0, chipReset}, 32'h0000_0001);
        extResetN <= 1'b1;
        wait_rst(1'b0, n);
        rd("flag_hw_clr", 12'h2a4, 32'h0000_0000, 1'b0);
        rd("live", 12'h004, 32'h0000_0004, 1'b0);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
